// >>> rtl/ctmr_top.sv
// Compact 16-bit timer with compare, timer and edge-aligned PWM modes.
// Assumes an APB master on pclk; sub_clock_tick is synchronous to pclk, the external pin is synchronised.
// Behaviour
// - Comparator P matches counter bits 15:8; zero means 65536, n means 256n.
// - Compare A value held in low and high byte registers, reset zero.
// - Clear-select low: P match clears counter; zero period runs to overflow.
// - Mode field: 00 compare output, 10 PWM, 11 timer/counter.
// - Compare mode, clear-select low: A and P flags set on their matches.
// - Clear-select high: A match clears counter, sets A flag only.
// - Clear-select high with compare zero: wrap at FFFF, no A flag.
// - Compare mode: pin changes only on A match, never on P match.
// - On A match output function: keep, low, high or toggle.
// - Run-enable rising edge loads the pin with the initial level.
// - Timer mode behaves as compare mode but does not drive the pin.
// - PWM mode ignores clear-select; swap bit picks the clearing source.
// - Swap 0: P sets period, A sets duty; swap 1 reverses roles.
// - PWM mode raises A and P flags on their matches.
// - PWM: initial bit picks active level, polarity inverts, function forces.
// - Swap 0 with duty at or above period gives 100% duty.
// - PWM counting and flags continue while output is forced.
// - Run-enable rise zeroes counter; clearing it holds the residual value.
// - Pause holds the counter; counting resumes from the held value.
// - Clock select: sys/4, sys, high/16, high/64, sub, external edges.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/100ps

module ctmr_top #(
  parameter int SYS_DIV  = ctmr_pkg::CTMR_SYS_DIV,
  parameter int FH_DIV_A = ctmr_pkg::CTMR_FH_DIV_A,
  parameter int FH_DIV_B = ctmr_pkg::CTMR_FH_DIV_B
) (
  // Clock and reset.
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Counting sources.
  input  wire logic               sub_clock_tick,
  input  wire logic               external_count_pin,
  // Timer output pin.
  output ctmr_pkg::ctmr_pin_type  timer_output_pin,
  // Match flag levels.
  output logic                    match_a_flag,
  output logic                    match_p_flag
);
  import ctmr_pkg::*;

  // The shared prescaler taps only serve the default divide ratios.
  if (SYS_DIV != 4 || FH_DIV_A != 16 || FH_DIV_B != 64) begin : g_bad_div
    $error("ctmr_top: prescaler supports divide ratios 4, 16, 64 only");
  end

  ctmr_ctrl0_type ctrl0_reg;
  ctmr_ctrl1_type ctrl1_reg;
  logic [7:0]     compare_a_low_byte_reg;
  logic [7:0]     compare_a_high_byte_reg;
  logic [7:0]     period_compare_byte_reg;
  logic [15:0]    count_reg;
  logic           run_prev_reg;
  logic [5:0]     presc_reg;
  logic [2:0]     ext_sync_reg;
  logic           level_reg;
  ctmr_pin_type   pin_reg;
  ctmr_pin_type   pin_next;
  logic [31:0]    prdata_reg;
  logic           flag_a_reg;
  logic           flag_p_reg;

  logic        setup;
  logic        access;
  logic        wr;
  logic        mapped;
  logic [7:0]  addr;
  logic [1:0]  mode;
  logic [1:0]  out_fn;
  logic        is_pwm;
  logic        run_rise;
  logic        tick;
  logic [15:0] compare_a_value;
  logic [16:0] count_inc;
  logic        a_hit;
  logic        p_hit;
  logic        clear_by_a;
  logic        clr_now;
  logic        set_a;
  logic        set_p;
  logic        clr_a;
  logic        clr_p;
  logic [16:0] duty;
  logic        pwm_act;

  assign addr    = paddr[7:0];
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign wr      = access && pwrite;
  assign mapped  = (paddr[31:8] == 24'h000000) && (addr[1:0] == 2'b00)
                   && (addr <= CTMR_OFS_FLAGS);
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = prdata_reg;

  assign mode   = {ctrl1_reg.mode_select_hi, ctrl1_reg.mode_select_lo};
  assign out_fn = {ctrl1_reg.output_function_hi,
                   ctrl1_reg.output_function_lo};
  assign is_pwm = (mode == CTMR_MODE_PWM);
  assign compare_a_value = {compare_a_high_byte_reg,
                            compare_a_low_byte_reg};

  // Register writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_reg               <= '0;
      ctrl1_reg               <= '0;
      compare_a_low_byte_reg  <= CTMR_BYTE_RESET;
      compare_a_high_byte_reg <= CTMR_BYTE_RESET;
      period_compare_byte_reg <= CTMR_BYTE_RESET;
    end else if (wr && mapped) begin
      case (addr)
        CTMR_OFS_CTRL0: begin
          ctrl0_reg <= ctmr_ctrl0_type'({pwdata[7:3], 3'b000});
        end
        CTMR_OFS_CTRL1: begin
          ctrl1_reg <= ctmr_ctrl1_type'(pwdata[7:0]);
        end
        CTMR_OFS_CMPA_LO: begin
          compare_a_low_byte_reg <= pwdata[7:0];
        end
        CTMR_OFS_CMPA_HI: begin
          compare_a_high_byte_reg <= pwdata[7:0];
        end
        CTMR_OFS_PERIOD: begin
          period_compare_byte_reg <= pwdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data is captured in the setup cycle and shown in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (setup) begin
      case (addr)
        CTMR_OFS_CTRL0:    prdata_reg <= {24'h000000, ctrl0_reg};
        CTMR_OFS_CTRL1:    prdata_reg <= {24'h000000, ctrl1_reg};
        CTMR_OFS_COUNT_LO: prdata_reg <= {24'h000000, count_reg[7:0]};
        CTMR_OFS_COUNT_HI: prdata_reg <= {24'h000000, count_reg[15:8]};
        CTMR_OFS_CMPA_LO:  prdata_reg <= {24'h000000, compare_a_low_byte_reg};
        CTMR_OFS_CMPA_HI:  prdata_reg <= {24'h000000, compare_a_high_byte_reg};
        CTMR_OFS_PERIOD:   prdata_reg <= {24'h000000, period_compare_byte_reg};
        CTMR_OFS_FLAGS:    prdata_reg <= {30'h0, flag_p_reg, flag_a_reg};
        default:           prdata_reg <= '0;
      endcase
    end
  end

  // Free-running prescaler and external pin synchroniser.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg    <= '0;
      ext_sync_reg <= '0;
    end else begin
      presc_reg    <= presc_reg + 6'h01;
      ext_sync_reg <= {ext_sync_reg[1:0], external_count_pin};
    end
  end

  // Counting event selection.
  always_comb begin
    case (ctrl0_reg.clock_select_field)
      CTMR_CLK_SYS4:  tick = (presc_reg[1:0] == 2'b11);
      CTMR_CLK_SYS:   tick = 1'b1;
      CTMR_CLK_FH16:  tick = (presc_reg[3:0] == 4'hf);
      CTMR_CLK_FH64:  tick = (presc_reg == 6'h3f);
      CTMR_CLK_SUB0,
      CTMR_CLK_SUB1:  tick = sub_clock_tick;
      CTMR_CLK_EXT_R: tick = ext_sync_reg[1] && !ext_sync_reg[2];
      CTMR_CLK_EXT_F: tick = !ext_sync_reg[1] && ext_sync_reg[2];
      default:        tick = 1'b0;
    endcase
  end

  assign run_rise  = ctrl0_reg.run_enable_bit && !run_prev_reg;
  assign count_inc = {1'b0, count_reg} + 17'h1;

  // Comparator A sees all 16 bits; a zero value never matches.
  assign a_hit = (count_inc[15:0] == compare_a_value)
                 && (compare_a_value != 16'h0000);

  // Comparator P sees bits 15:8; a zero value matches on overflow.
  assign p_hit = (period_compare_byte_reg == 8'h00) ? count_inc[16]
               : (count_inc[15:0] == {period_compare_byte_reg, 8'h00});

  assign clear_by_a = is_pwm ? ctrl1_reg.duty_period_swap
                             : ctrl1_reg.clear_select_bit;
  assign clr_now = clear_by_a ? a_hit : p_hit;

  // Counting advances only while running and not paused.
  assign set_a = ctrl0_reg.run_enable_bit && !ctrl0_reg.pause_bit && tick
                 && a_hit;
  assign set_p = ctrl0_reg.run_enable_bit && !ctrl0_reg.pause_bit && tick
                 && p_hit && (is_pwm || !ctrl1_reg.clear_select_bit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg    <= '0;
      run_prev_reg <= 1'b0;
    end else begin
      run_prev_reg <= ctrl0_reg.run_enable_bit;
      if (run_rise) begin
        count_reg <= '0;
      end else if (ctrl0_reg.run_enable_bit && !ctrl0_reg.pause_bit
                   && tick) begin
        count_reg <= clr_now ? 16'h0000 : count_inc[15:0];
      end
    end
  end

  // Sticky flags, cleared by writing one; a new match wins over the clear.
  assign clr_a = wr && mapped && (addr == CTMR_OFS_FLAGS)
                 && pwdata[CTMR_FLAG_A_POS];
  assign clr_p = wr && mapped && (addr == CTMR_OFS_FLAGS)
                 && pwdata[CTMR_FLAG_P_POS];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_a_reg <= 1'b0;
      flag_p_reg <= 1'b0;
    end else begin
      flag_a_reg <= set_a || (flag_a_reg && !clr_a);
      flag_p_reg <= set_p || (flag_p_reg && !clr_p);
    end
  end

  assign match_a_flag = flag_a_reg;
  assign match_p_flag = flag_p_reg;

  // Compare-mode output level, before polarity.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= 1'b0;
    end else if (run_rise) begin
      level_reg <= ctrl1_reg.output_initial_control;
    end else if (set_a && mode == CTMR_MODE_COMPARE) begin
      case (out_fn)
        CTMR_FN_KEEP:   level_reg <= level_reg;
        CTMR_FN_LOW:    level_reg <= 1'b0;
        CTMR_FN_HIGH:   level_reg <= 1'b1;
        CTMR_FN_TOGGLE: level_reg <= !level_reg;
        default:        level_reg <= level_reg;
      endcase
    end
  end

  // PWM duty: compare A when unswapped, period byte times 256 when swapped.
  always_comb begin
    if (!ctrl1_reg.duty_period_swap) begin
      duty = {1'b0, compare_a_value};
    end else if (period_compare_byte_reg == 8'h00) begin
      duty = 17'h10000;
    end else begin
      duty = {1'b0, period_compare_byte_reg, 8'h00};
    end
  end

  // The count never reaches the period, so duty at or above it stays active.
  assign pwm_act = ({1'b0, count_reg} < duty);

  always_comb begin
    pin_next.oe  = 1'b1;
    pin_next.out = 1'b0;
    case (mode)
      CTMR_MODE_COMPARE: begin
        pin_next.out = level_reg ^ ctrl1_reg.output_polarity_bit;
      end
      CTMR_MODE_PWM: begin
        case (out_fn)
          CTMR_PWM_RUN:    pin_next.out = pwm_act;
          CTMR_PWM_ACTIVE: pin_next.out = 1'b1;
          default:         pin_next.out = 1'b0;
        endcase
        pin_next.out = (ctrl1_reg.output_initial_control ? pin_next.out
                        : !pin_next.out)
                       ^ ctrl1_reg.output_polarity_bit;
      end
      default: begin
        pin_next.oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_reg <= '0;
    end else begin
      pin_reg <= pin_next;
    end
  end

  assign timer_output_pin = pin_reg;

endmodule

// >>> rtl/ctmr_pkg.sv
// Package for the compact timer: register map, field layouts and constants.
// Assumes a 32-bit APB slave with one aligned word per register.
package ctmr_pkg;

  localparam logic [7:0] CTMR_OFS_CTRL0     = 8'h00;
  localparam logic [7:0] CTMR_OFS_CTRL1     = 8'h04;
  localparam logic [7:0] CTMR_OFS_COUNT_LO  = 8'h08;
  localparam logic [7:0] CTMR_OFS_COUNT_HI  = 8'h0c;
  localparam logic [7:0] CTMR_OFS_CMPA_LO   = 8'h10;
  localparam logic [7:0] CTMR_OFS_CMPA_HI   = 8'h14;
  localparam logic [7:0] CTMR_OFS_PERIOD    = 8'h18;
  localparam logic [7:0] CTMR_OFS_FLAGS     = 8'h1c;

  localparam int CTMR_FLAG_A_POS = 0;
  localparam int CTMR_FLAG_P_POS = 1;

  localparam logic [7:0] CTMR_BYTE_RESET = 8'h00;

  // Prescaler divide ratios of the internal counting clocks.
  localparam int CTMR_SYS_DIV = 4;
  localparam int CTMR_FH_DIV_A = 16;
  localparam int CTMR_FH_DIV_B = 64;

  localparam logic [1:0] CTMR_MODE_COMPARE = 2'b00;
  localparam logic [1:0] CTMR_MODE_PWM     = 2'b10;
  localparam logic [1:0] CTMR_MODE_TIMER   = 2'b11;

  localparam logic [1:0] CTMR_FN_KEEP   = 2'b00;
  localparam logic [1:0] CTMR_FN_LOW    = 2'b01;
  localparam logic [1:0] CTMR_FN_HIGH   = 2'b10;
  localparam logic [1:0] CTMR_FN_TOGGLE = 2'b11;

  localparam logic [1:0] CTMR_PWM_INACTIVE = 2'b00;
  localparam logic [1:0] CTMR_PWM_ACTIVE   = 2'b01;
  localparam logic [1:0] CTMR_PWM_RUN      = 2'b10;

  localparam logic [2:0] CTMR_CLK_SYS4  = 3'b000;
  localparam logic [2:0] CTMR_CLK_SYS   = 3'b001;
  localparam logic [2:0] CTMR_CLK_FH16  = 3'b010;
  localparam logic [2:0] CTMR_CLK_FH64  = 3'b011;
  localparam logic [2:0] CTMR_CLK_SUB0  = 3'b100;
  localparam logic [2:0] CTMR_CLK_SUB1  = 3'b101;
  localparam logic [2:0] CTMR_CLK_EXT_R = 3'b110;
  localparam logic [2:0] CTMR_CLK_EXT_F = 3'b111;

  typedef struct packed {
    logic       pause_bit;
    logic [2:0] clock_select_field;
    logic       run_enable_bit;
    logic [2:0] unused;
  } ctmr_ctrl0_type;

  typedef struct packed {
    logic       mode_select_hi;
    logic       mode_select_lo;
    logic       output_function_hi;
    logic       output_function_lo;
    logic       output_initial_control;
    logic       output_polarity_bit;
    logic       duty_period_swap;
    logic       clear_select_bit;
  } ctmr_ctrl1_type;

  typedef struct packed {
    logic       out;
    logic       oe;
  } ctmr_pin_type;

endpackage

// >>> verification/ctmr_assertions.sv
// Checker for the compact timer, bound to the top module.
// Assumes an APB master on pclk and the register map of ctmr_pkg.
`timescale 1ns/100ps

module ctmr_checker
  import ctmr_pkg::*;
#(
  parameter int SYS_DIV  = CTMR_SYS_DIV,
  parameter int FH_DIV_A = CTMR_FH_DIV_A,
  parameter int FH_DIV_B = CTMR_FH_DIV_B
) (
  // Clock and reset.
  input wire logic                   pclk,
  input wire logic                   presetn,
  // APB.
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [31:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // Counting sources and outputs.
  input wire logic                   sub_clock_tick,
  input wire logic                   external_count_pin,
  input wire ctmr_pkg::ctmr_pin_type timer_output_pin,
  input wire logic                   match_a_flag,
  input wire logic                   match_p_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ctmr_ctrl1_type c1_reg;
  logic           run_reg;
  logic [2:0]     age_reg;
  logic           wr;
  logic           ok;
  logic [1:0]     mode;
  logic           act;
  logic           pout;

  assign wr   = psel && penable && pwrite;
  assign ok   = paddr[31:5] == 27'h0 && paddr[1:0] == 2'h0;
  assign mode = {c1_reg.mode_select_hi, c1_reg.mode_select_lo};
  assign act  = c1_reg.output_initial_control ^ c1_reg.output_polarity_bit;
  assign pout = timer_output_pin.out;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      c1_reg <= '0;
    else if (wr && paddr[7:0] == CTMR_OFS_CTRL1)
      c1_reg <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      run_reg <= 1'h0;
    else if (wr && paddr[7:0] == CTMR_OFS_CTRL0)
      run_reg <= pwdata[3];
  end

  // Cycles since the last control write, so pin checks skip the settling.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      age_reg <= 3'h0;
    else if (wr && paddr[7:3] == 5'h0)
      age_reg <= 3'h0;
    else if (age_reg != 3'h7)
      age_reg <= age_reg + 3'h1;
  end

  a_pready_high: assert property (pready)
    else $error("pready low in a cycle");
  a_err_unmapped: assert property (psel && penable && !ok |-> pslverr)
    else $error("unmapped access without error");
  a_flag_a_hold: assert property (match_a_flag && !(wr && pwdata[0] &&
    paddr[7:0] == CTMR_OFS_FLAGS) |=> match_a_flag)
    else $error("flag a dropped without clear");
  a_flag_p_hold: assert property (match_p_flag && !(wr && pwdata[1] &&
    paddr[7:0] == CTMR_OFS_FLAGS) |=> match_p_flag)
    else $error("flag p dropped without clear");
  a_timer_no_drive: assert property (mode == CTMR_MODE_TIMER &&
    age_reg == 3'h7 |-> !timer_output_pin.oe)
    else $error("pin driven in timer mode");
  a_pin_on_a: assert property (mode == CTMR_MODE_COMPARE &&
    age_reg == 3'h7 && $changed(pout) |-> $past(match_a_flag))
    else $error("pin moved without a match of a");
  a_pwm_forced: assert property (mode == CTMR_MODE_PWM && run_reg &&
    age_reg == 3'h7 && !c1_reg.output_function_hi |->
    pout == (c1_reg.output_function_lo ? act : !act))
    else $error("forced pwm level wrong");
  a_no_p_flag: assert property (mode != CTMR_MODE_PWM &&
    c1_reg.clear_select_bit && age_reg == 3'h7 |-> !$rose(match_p_flag))
    else $error("p flag raised while clearing on a");
  a_run_init: assert property ($rose(run_reg) &&
    mode == CTMR_MODE_COMPARE |-> ##[1:3] pout == act)
    else $error("pin not loaded on run");

  c_pwm_high: cover property (mode == CTMR_MODE_PWM && pout);
  c_flag_p: cover property ($rose(match_p_flag));
  c_timer_a: cover property (mode == CTMR_MODE_TIMER && $rose(match_a_flag));
endmodule

bind ctmr_top ctmr_checker #(
  .SYS_DIV(SYS_DIV), .FH_DIV_A(FH_DIV_A), .FH_DIV_B(FH_DIV_B)
) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .sub_clock_tick, .external_count_pin,
  .timer_output_pin, .match_a_flag, .match_p_flag
);

// >>> verification/ctmr_tb_top.sv
// Self-checking bench for the compact timer over its APB port.
// Assumes period byte 1; the slow counting sources come from a bench counter.
`timescale 1ns/100ps

module ctmr_tb_top;
  import ctmr_pkg::*;

  logic         pclk = 1'h0;
  logic         presetn = 1'h0;
  logic         psel = 1'h0;
  logic         penable = 1'h0;
  logic         pwrite = 1'h0;
  logic [31:0]  paddr = 32'h0;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  ctmr_pin_type pin;
  logic         fa;
  logic         fp;
  int           mismatches = 0;
  int           num_checks = 0;
  logic [31:0]  r;
  logic         e;
  logic [31:0]  h;
  logic [7:0]   tbc = 8'h00;
  // Count increments over 256 cycles for each clock select, low byte only.
  logic [31:0]  ticks [8] = '{32'h40, 32'h00, 32'h10, 32'h04, 32'h20, 32'h20,
    32'h08, 32'h08};
  // Address, write data, expected read, expected error.
  logic [24:0]  regrow [5] = '{{CTMR_OFS_CMPA_LO, 8'ha5, 8'ha5, 1'h0},
    {CTMR_OFS_CMPA_HI, 8'h5a, 8'h5a, 1'h0}, {CTMR_OFS_PERIOD, 8'h3c, 8'h3c,
    1'h0}, {CTMR_OFS_COUNT_HI, 8'h77, 8'h00, 1'h0}, {8'h22, 8'hff, 8'h00,
    1'h1}};
  // Control, compare high, compare low, window, expected high cycles.
  logic [55:0]  pwmrow [4] = '{{24'ha80040, 16'h0100, 16'h0040},
    {24'hac0040, 16'h0100, 16'h00c0}, {24'ha80200, 16'h0100, 16'h0100},
    {24'haa0200, 16'h0200, 16'h0100}};

  ctmr_top uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sub_clock_tick(tbc[2:0] == 3'h7),
    .external_count_pin(tbc[4]),
    .timer_output_pin(pin), .match_a_flag(fa), .match_p_flag(fp)
  );

  always #5 pclk = ~pclk;

  // Sub clock pulse every 8 cycles, external pin rising edges every 32 cycles.
  always @(posedge pclk) begin
    tbc <= tbc + 8'h01;
  end

  task automatic summarize();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, d);
    @(posedge pclk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= {24'h0, a};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic cfg(input logic [7:0] c1, hi, lo);
    apb(1'h1, CTMR_OFS_CTRL0, 8'h10);
    apb(1'h1, CTMR_OFS_CTRL1, c1);
    apb(1'h1, CTMR_OFS_PERIOD, 8'h01);
    apb(1'h1, CTMR_OFS_CMPA_HI, hi);
    apb(1'h1, CTMR_OFS_CMPA_LO, lo);
    apb(1'h1, CTMR_OFS_FLAGS, 8'h03);
    apb(1'h1, CTMR_OFS_CTRL0, 8'h18);
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge pclk);
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    foreach (regrow[i]) begin
      apb(1'h1, regrow[i][24:17], regrow[i][16:9]);
      apb(1'h0, regrow[i][24:17], 8'h00);
      chk("read", r, {24'h0, regrow[i][8:1]});
      chk("error", {31'h0, e}, {31'h0, regrow[i][0]});
    end
    @(posedge pclk);
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 3; i++) begin
      apb(1'h0, regrow[i][24:17], 8'h00);
      chk("reset value", r, 32'h0);
    end
    // Compare 0x0120 lies beyond the first period match at 256.
    for (int f = 0; f < 4; f++) begin
      cfg({2'h0, f[1:0], 4'h9}, 8'h01, 8'h20);
      wt(4);
      chk("initial level", {31'h0, pin.out}, 32'h1);
      wt(300);
      chk("pin after match", {31'h0, pin.out}, {31'h0, ~f[0]});
      chk("flags", {30'h0, fp, fa}, 32'h1);
    end
    cfg(8'h30, 8'h00, 8'h80);
    wt(140);
    chk("flags a only", {30'h0, fp, fa}, 32'h1);
    wt(130);
    chk("flags both", {30'h0, fp, fa}, 32'h3);
    chk("pin after p", {31'h0, pin.out}, 32'h1);
    apb(1'h0, CTMR_OFS_COUNT_HI, 8'h00);
    chk("cleared count", r, 32'h0);
    cfg(8'hf0, 8'h00, 8'h80);
    wt(140);
    chk("timer pin", {30'h0, pin.oe, fa}, 32'h1);
    apb(1'h1, CTMR_OFS_CTRL0, 8'h98);
    apb(1'h0, CTMR_OFS_COUNT_LO, 8'h00);
    h = r;
    wt(10);
    apb(1'h0, CTMR_OFS_COUNT_LO, 8'h00);
    chk("paused count", r, h);
    apb(1'h1, CTMR_OFS_CTRL0, 8'h10);
    apb(1'h0, CTMR_OFS_COUNT_LO, 8'h00);
    h = r;
    wt(10);
    apb(1'h0, CTMR_OFS_COUNT_LO, 8'h00);
    chk("stopped count", r, h);
    apb(1'h1, CTMR_OFS_CTRL0, 8'h18);
    apb(1'h0, CTMR_OFS_COUNT_LO, 8'h00);
    chk("restart", {31'h0, r < 32'h10}, 32'h1);
    foreach (pwmrow[i]) begin
      cfg(pwmrow[i][55:48], pwmrow[i][47:40], pwmrow[i][39:32]);
      wt(600);
      h = 32'h0;
      repeat (pwmrow[i][31:16]) begin
        @(negedge pclk);
        if (pin.out === 1'h1) h++;
      end
      chk("pwm high", h, {16'h0, pwmrow[i][15:0]});
    end
    cfg(8'h88, 8'h00, 8'h40);
    wt(300);
    chk("forced flags", {30'h0, fp, fa}, 32'h3);
    // Compare zero never matches; reads 256 cycles apart give the rate.
    cfg(8'h01, 8'h00, 8'h00);
    for (int s = 0; s < 8; s++) begin
      apb(1'h1, CTMR_OFS_CTRL0, 8'h00);
      apb(1'h1, CTMR_OFS_CTRL0, {1'h0, s[2:0], 4'h8});
      apb(1'h0, CTMR_OFS_COUNT_LO, 8'h00);
      h = r;
      wt(254);
      apb(1'h0, CTMR_OFS_COUNT_LO, 8'h00);
      chk("count rate", {24'h0, r[7:0] - h[7:0]}, ticks[s]);
    end
    chk("flag a at zero", {31'h0, fa}, 32'h0);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    summarize();
  end
endmodule
